// file: bench/scoc_host.sv
`timescale 1ns/1ps
module scoc_host (
   // Clock
   input wire logic         clk,
   // Register port
   output logic [7:0]       reg_addr,
   output logic [15:0]      reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input wire logic [15:0]  reg_rdata,
   // Converter and modulator
   output logic             converter_enable,
   output logic             mod_bit,
   output logic             mod_valid
);
   logic level;
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, mod_bit, mod_valid} = '0;
      converter_enable = 1'b1;
      level = 1'b1;
   end
   // Modulator delivers a sample every cycle
   always @(negedge clk) begin
      mod_valid <= 1'b1;
      mod_bit <= level;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = (a == 8'hC7) ? (d & 16'hDFFF) : d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~reg_wdata;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
endmodule // scoc_host

// file: bench/scoc_top_asserts.sv
`timescale 1ns/1ps
module scoc_chk (
   // Clock and reset
   input wire logic                   clk,
   input wire logic                   rst_b,
   // Register port
   input wire logic [7:0]             reg_addr,
   input wire logic                   reg_rd,
   input wire logic [15:0]            reg_rdata,
   // Converter and correction
   input wire logic                   converter_enable,
   input wire logic                   raw_valid,
   input wire logic                   corrected_valid,
   // Comparator and pin
   input wire scoc_pkg::scoc_limit_t  overcurrent_b_upper_limit,
   input wire scoc_pkg::scoc_limit_t  overcurrent_b_lower_limit,
   input wire logic                   shared_pin_source_select,
   input wire scoc_pkg::scoc_fmt_t    shared_pin_output_format,
   input wire logic                   shared_pin_gpio_level,
   input wire logic                   shared_pin_out,
   input wire logic                   shared_pin_oe,
   input wire logic                   overcurrent_b_high_event,
   input wire logic                   overcurrent_b_low_event,
   input wire scoc_pkg::scoc_limit_t  fast_filter_result
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   unmapped_read_a: assert property (
      reg_rd && (reg_addr < 8'hC4 || reg_addr > 8'hC7) |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   reserved_read_a: assert property (
      reg_rd && (reg_addr == 8'hC5 || reg_addr == 8'hC7) |=> reg_rdata[7:0] == 8'h00)
      else $error("reserved bits not zero");
   events_off_a: assert property (
      !converter_enable |=> !overcurrent_b_high_event && !overcurrent_b_low_event)
      else $error("events survive disable");
   gpio_pass_a: assert property (
      !shared_pin_source_select && shared_pin_output_format == scoc_pkg::SCOC_FMT_PUSH_PULL
      |=> shared_pin_oe && shared_pin_out == $past(shared_pin_gpio_level))
      else $error("pin not following gpio level");
   open_drain_a: assert property (
      shared_pin_output_format == scoc_pkg::SCOC_FMT_OPEN_DRAIN |=> !shared_pin_out)
      else $error("open drain drives high");
   fault_pin_a: assert property (
      $changed(overcurrent_b_high_event | overcurrent_b_low_event)
      && shared_pin_source_select && $stable(shared_pin_source_select)
      && shared_pin_output_format == scoc_pkg::SCOC_FMT_PUSH_PULL
      |=> shared_pin_out != $past(shared_pin_out))
      else $error("pin missed fault change");
   corr_valid_a: assert property (
      raw_valid |=> corrected_valid)
      else $error("corrected result missing");
   high_above_a: assert property (
      $rose(overcurrent_b_high_event) |-> fast_filter_result > overcurrent_b_upper_limit)
      else $error("high event without crossing");
   low_below_a: assert property (
      $rose(overcurrent_b_low_event) |-> fast_filter_result < overcurrent_b_lower_limit)
      else $error("low event without crossing");
endmodule // scoc_chk
bind scoc_top scoc_chk scoc_chk_inst (.clk, .rst_b, .reg_addr, .reg_rd, .reg_rdata,
   .converter_enable, .raw_valid, .corrected_valid, .overcurrent_b_upper_limit,
   .overcurrent_b_lower_limit, .shared_pin_source_select, .shared_pin_output_format,
   .shared_pin_gpio_level, .shared_pin_out, .shared_pin_oe, .overcurrent_b_high_event,
   .overcurrent_b_low_event, .fast_filter_result);

// file: bench/scoc_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module scoc_top_tb;
   logic                   clk, rst_b, reg_wr, reg_rd, converter_enable, mod_bit, mod_valid;
   logic [7:0]             reg_addr;
   logic [15:0]            reg_wdata, reg_rdata, d;
   logic                   start, stop, raw_valid, corrected_valid;
   logic                   src, gpio_level, pin_out, pin_oe, hi_ev, lo_ev;
   scoc_pkg::scoc_sample_t raw_data, corrected_data, off;
   scoc_pkg::scoc_limit_t  upper, lower, ff_res, g;
   scoc_pkg::scoc_fmt_t    fmt;
   int                     seed = 31466;
   int                     compares, miscompares, cyc, t0, k;
   int                     tbl[22] = '{12, 14, 16, 18, 20, 22, 24, 26, 28, 32, 40,
                                       48, 56, 64, 72, 80, 88, 96, 104, 112, 120, 128};
   logic [15:0]            msk[4] = '{16'hFFFF, 16'hFF00, 16'hFFFF, 16'hDF00};
   logic [15:0]            mdl[4];
   longint                 p;
   scoc_host scoc_host_inst (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .converter_enable, .mod_bit, .mod_valid);
   scoc_top scoc_top_inst (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .converter_enable, .shunt_b_conversion_start(start), .shunt_b_conversion_stop(stop),
      .mod_bit, .mod_valid, .raw_data, .raw_valid, .corrected_data, .corrected_valid,
      .overcurrent_b_upper_limit(upper), .overcurrent_b_lower_limit(lower),
      .shared_pin_source_select(src), .shared_pin_output_format(fmt),
      .shared_pin_gpio_level(gpio_level), .shared_pin_out(pin_out), .shared_pin_oe(pin_oe),
      .overcurrent_b_high_event(hi_ev), .overcurrent_b_low_event(lo_ev),
      .fast_filter_result(ff_res));
   task automatic conclude;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic nclk(input int n);
      repeat (n) @(negedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Start and stop toggle at random to show the fast path ignores them
   always @(negedge clk) begin
      {start, stop, gpio_level} <= 3'($random(seed));
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 98000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      {rst_b, start, stop, gpio_level, raw_valid, src, cyc} = '0;
      raw_data = '0;
      upper = 16'h7FFF;
      lower = 16'h8000;
      fmt = scoc_pkg::SCOC_FMT_PUSH_PULL;
      nclk(10);
      rst_b = 1'b1;
      for (int a = 0; a < 4; a++) mdl[a] = 16'h0000;
      repeat (2) begin
         for (int a = 0; a < 4; a++) begin
            scoc_host_inst.rd(8'hC4 + 8'(a), d);
            `CHK("reg", mdl[a], d)
            d = 16'($random(seed));
            scoc_host_inst.wr(8'hC4 + 8'(a), d);
            mdl[a] = d & msk[a];
         end
      end
      scoc_host_inst.wr(8'hC8, 16'hFFFF);
      scoc_host_inst.rd(8'hC8, d);
      `CHK("unmapped", 16'h0000, d)
      scoc_host_inst.wr(8'hC7, 16'h0000);
      $display("register test done");
      for (int i = 0; i < 16; i++) begin
         off = 24'($random(seed));
         g = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h8000 : 16'($random(seed));
         scoc_host_inst.wr(8'hC4, off[23:8]);
         scoc_host_inst.wr(8'hC5, {off[7:0], 8'hA5});
         scoc_host_inst.wr(8'hC6, g);
         raw_data = 24'($random(seed));
         raw_valid = 1'b1;
         nclk(1);
         raw_valid = 1'b0;
         p = ((longint'(raw_data) - longint'(off)) * (65536 + longint'(g))) >>> 16;
         p = (p > 8388607) ? 8388607 : (p < -8388608) ? -8388608 : p;
         `CHK("corrected", 24'(p), corrected_data)
      end
      $display("correction test done");
      src = 1'b1;
      scoc_host_inst.wr(8'hC7, 16'hC000);
      t0 = cyc;
      nclk(256);
      `CHK("filter", 16'h7FFF, ff_res)
      `CHK("high off", 1'b0, hi_ev)
      for (int c = 0; c < 32; c++) begin
         scoc_host_inst.wr(8'hC7, {3'b110, 5'(c), 8'h00});
         // Change limits mid-frame so each wait of 64 spans one filter output
         while ((cyc - t0) % 64 != 32) @(negedge clk);
         upper = 16'h0000;
         k = 0;
         do begin
            nclk(64);
            k++;
         end while (hi_ev !== 1'b1 && k < 140);
         `CHK("deglitch", (c < 10) ? c + 1 : tbl[c - 10], k)
         `CHK("pin", 1'b1, pin_out)
         upper = 16'h7FFF;
         nclk(64);
         `CHK("cleared", 1'b0, hi_ev)
      end
      $display("deglitch test done");
      scoc_host_inst.level = 1'b0;
      lower = 16'h0000;
      scoc_host_inst.wr(8'hC7, 16'h8200);
      nclk(512);
      `CHK("filter", 16'h8000, ff_res)
      `CHK("low", 1'b1, lo_ev)
      `CHK("pin", 1'b0, pin_out)
      fmt = scoc_pkg::SCOC_FMT_OPEN_DRAIN;
      nclk(2);
      `CHK("oe", 1'b1, pin_oe)
      scoc_host_inst.converter_enable = 1'b0;
      nclk(2);
      `CHK("low off", 1'b0, lo_ev)
      scoc_host_inst.converter_enable = 1'b1;
      scoc_host_inst.wr(8'hC7, 16'h0200);
      nclk(300);
      `CHK("comparator off", 1'b0, lo_ev)
      $display("low event test done");
      conclude();
   end
endmodule // scoc_top_tb

// file: hdl/scoc_ff_if.sv
`timescale 1ns/1ps
interface scoc_ff_if;
   logic                  run;
   logic                  mod_bit;
   logic                  mod_valid;
   scoc_pkg::scoc_ff_word_t result;
   logic                  result_valid;
   modport filt (input run, input mod_bit, input mod_valid, output result, output result_valid);
   modport user (output run, output mod_bit, output mod_valid, input result, input result_valid);
endinterface

// file: hdl/scoc_pkg.sv
package scoc_pkg;
   typedef logic signed [19:0] scoc_ff_word_t;
   typedef logic signed [15:0] scoc_limit_t;
   typedef logic signed [23:0] scoc_sample_t;
   typedef logic [7:0]         scoc_count_t;
   typedef enum logic { SCOC_FMT_PUSH_PULL, SCOC_FMT_OPEN_DRAIN } scoc_fmt_t;
endpackage

// file: hdl/scoc_regs.svh
`ifndef SCOC_REGS_SVH
`define SCOC_REGS_SVH

// Register indices on the 8-bit register port
`define SCOC_ADDR_OFFSET_HIGH   8'hC4
`define SCOC_ADDR_OFFSET_LOW    8'hC5
`define SCOC_ADDR_GAIN_CORR     8'hC6
`define SCOC_ADDR_OC_CONFIG     8'hC7

// Reset values
`define SCOC_RST_OFFSET_HIGH    16'h0000
`define SCOC_RST_OFFSET_LOW     8'h00
`define SCOC_RST_GAIN_CORR      16'h0000
`define SCOC_RST_DEGLITCH       5'h00

// Field positions
`define SCOC_OFFL_MSB           15
`define SCOC_OFFL_LSB           8
`define SCOC_CFG_EN_BIT         15
`define SCOC_CFG_POL_BIT        14
`define SCOC_CFG_RSV_BIT        13
`define SCOC_CFG_NUM_MSB        12
`define SCOC_CFG_NUM_LSB        8

// Fast filter timing and scaling, gain correction scaling
`define SCOC_FF_OSR_LAST        6'h3F
`define SCOC_FF_SHIFT           3
`define SCOC_GAIN_UNITY         18'sh10000
`define SCOC_GAIN_SHIFT         16

`endif

// file: hdl/scoc_sinc3.sv
`timescale 1ns/1ps
`include "scoc_regs.svh"
module scoc_sinc3 (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Filter port
   scoc_ff_if.filt  ff
);
   scoc_pkg::scoc_ff_word_t i1_q, i2_q, i3_q, d1_q, d2_q, d3_q, res_q;
   scoc_pkg::scoc_ff_word_t i1_d, i2_d, i3_d, d1_d, d2_d, d3_d, res_d;
   scoc_pkg::scoc_ff_word_t c1, c2, c3, x;
   logic [5:0]              cnt_q, cnt_d;
   logic                    vld_q, vld_d;

   // Widths wrap modulo 2^20, which the comb stages undo exactly
   always_comb begin
      i1_d  = i1_q;
      i2_d  = i2_q;
      i3_d  = i3_q;
      d1_d  = d1_q;
      d2_d  = d2_q;
      d3_d  = d3_q;
      res_d = res_q;
      cnt_d = cnt_q;
      vld_d = 1'b0;
      x     = ff.mod_bit ? 20'sh00001 : 20'shFFFFF;
      c1    = i3_q - d1_q;
      c2    = c1 - d2_q;
      c3    = c2 - d3_q;
      if (!ff.run) begin
         i1_d  = '0;
         i2_d  = '0;
         i3_d  = '0;
         d1_d  = '0;
         d2_d  = '0;
         d3_d  = '0;
         cnt_d = '0;
      end else if (ff.mod_valid) begin
         i1_d  = i1_q + x;
         i2_d  = i2_q + i1_q;
         i3_d  = i3_q + i2_q;
         cnt_d = cnt_q + 6'h01;
         if (cnt_q == `SCOC_FF_OSR_LAST) begin
            d1_d  = i3_q;
            d2_d  = c1;
            d3_d  = c2;
            res_d = c3;
            vld_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         i1_q  <= '0;
         i2_q  <= '0;
         i3_q  <= '0;
         d1_q  <= '0;
         d2_q  <= '0;
         d3_q  <= '0;
         res_q <= '0;
         cnt_q <= '0;
         vld_q <= 1'b0;
      end else begin
         i1_q  <= i1_d;
         i2_q  <= i2_d;
         i3_q  <= i3_d;
         d1_q  <= d1_d;
         d2_q  <= d2_d;
         d3_q  <= d3_d;
         res_q <= res_d;
         cnt_q <= cnt_d;
         vld_q <= vld_d;
      end
   end

   assign ff.result       = res_q;
   assign ff.result_valid = vld_q;
endmodule // scoc_sinc3

// file: hdl/scoc_top.sv
`timescale 1ns/1ps
`include "scoc_regs.svh"
// Notes on behaviour
// - Offset low byte lives in bits 15:8
// - High and low parts form 24-bit signed offset
// - Reserved low bytes read zero, writes ignored; C7 bit 13 is stored and reads back
// - Gain is one plus signed value over 2^16
// - Enable bit runs fast filter and comparator
// - Start and stop never touch fast filter
// - Polarity bit picks fault level on pin
// - Fault is high event OR low event
// - Pin shows fault only when selected, formatted
// - Event after programmed count of conversions exceeded
// - Fast filter is sinc3 with OSR 64
// - Counter restarts when inside threshold, no hysteresis
// - Above high limit raises high event; 7FFF disables
// - Below low limit raises low event; 8000 disables
module scoc_top (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   // Register port
   input  wire logic [7:0]           reg_addr,
   input  wire logic [15:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [15:0]               reg_rdata,
   // Converter state and modulator stream
   input  wire logic                 converter_enable,
   input  wire logic                 shunt_b_conversion_start,
   input  wire logic                 shunt_b_conversion_stop,
   input  wire logic                 mod_bit,
   input  wire logic                 mod_valid,
   // Main conversion result and its corrected form
   input  wire scoc_pkg::scoc_sample_t raw_data,
   input  wire logic                 raw_valid,
   output scoc_pkg::scoc_sample_t    corrected_data,
   output logic                      corrected_valid,
   // Comparator limits
   input  wire scoc_pkg::scoc_limit_t overcurrent_b_upper_limit,
   input  wire scoc_pkg::scoc_limit_t overcurrent_b_lower_limit,
   // Shared pin control
   input  wire logic                 shared_pin_source_select,
   input  wire scoc_pkg::scoc_fmt_t  shared_pin_output_format,
   input  wire logic                 shared_pin_gpio_level,
   output logic                      shared_pin_out,
   output logic                      shared_pin_oe,
   // Comparator state
   output logic                      overcurrent_b_high_event,
   output logic                      overcurrent_b_low_event,
   output scoc_pkg::scoc_limit_t     fast_filter_result
);
   scoc_ff_if ffi ();

   logic [15:0]             offh_q, offh_d, gain_q, gain_d, rdata_q, rdata_d;
   logic [7:0]              offl_q, offl_d;
   logic                    en_q, en_d, pol_q, pol_d, rsv_q, rsv_d;
   logic [4:0]              num_q, num_d;
   scoc_pkg::scoc_sample_t  corr_q, corr_d;
   logic                    cvld_q, cvld_d;
   scoc_pkg::scoc_count_t   hcnt_q, hcnt_d, lcnt_q, lcnt_d, need;
   logic                    hev_q, hev_d, lev_q, lev_d;
   scoc_pkg::scoc_limit_t   ffr_q, ffr_d, scaled;
   logic                    pout_q, pout_d, poe_q, poe_d;
   logic signed [23:0]      offset;
   logic signed [24:0]      diff;
   logic signed [17:0]      gfac;
   logic signed [42:0]      prod;
   logic                    run, fault, level;

   // Deglitch code to conversions; coarser steps above ten
   function automatic scoc_pkg::scoc_count_t deglitch_len(input logic [4:0] code);
      case (code)
         5'h0A:   deglitch_len = 8'h0C;
         5'h0B:   deglitch_len = 8'h0E;
         5'h0C:   deglitch_len = 8'h10;
         5'h0D:   deglitch_len = 8'h12;
         5'h0E:   deglitch_len = 8'h14;
         5'h0F:   deglitch_len = 8'h16;
         5'h10:   deglitch_len = 8'h18;
         5'h11:   deglitch_len = 8'h1A;
         5'h12:   deglitch_len = 8'h1C;
         5'h13:   deglitch_len = 8'h20;
         5'h14:   deglitch_len = 8'h28;
         5'h15:   deglitch_len = 8'h30;
         5'h16:   deglitch_len = 8'h38;
         5'h17:   deglitch_len = 8'h40;
         5'h18:   deglitch_len = 8'h48;
         5'h19:   deglitch_len = 8'h50;
         5'h1A:   deglitch_len = 8'h58;
         5'h1B:   deglitch_len = 8'h60;
         5'h1C:   deglitch_len = 8'h68;
         5'h1D:   deglitch_len = 8'h70;
         5'h1E:   deglitch_len = 8'h78;
         5'h1F:   deglitch_len = 8'h80;
         default: deglitch_len = {3'h0, code} + 8'h01;
      endcase
   endfunction

   // Counter saturates at the target so a long fault cannot wrap it
   function automatic scoc_pkg::scoc_count_t dg_next(input logic hit,
                                                     input scoc_pkg::scoc_count_t cnt,
                                                     input scoc_pkg::scoc_count_t tgt);
      if (!hit)
         dg_next = 8'h00;
      else if (cnt < tgt)
         dg_next = cnt + 8'h01;
      else
         dg_next = cnt;
   endfunction

   // Register file
   always_comb begin
      offh_d  = offh_q;
      offl_d  = offl_q;
      gain_d  = gain_q;
      en_d    = en_q;
      pol_d   = pol_q;
      rsv_d   = rsv_q;
      num_d   = num_q;
      rdata_d = rdata_q;
      if (reg_wr) begin
         case (reg_addr)
            `SCOC_ADDR_OFFSET_HIGH: offh_d = reg_wdata;
            `SCOC_ADDR_OFFSET_LOW:  offl_d = reg_wdata[`SCOC_OFFL_MSB:`SCOC_OFFL_LSB];
            `SCOC_ADDR_GAIN_CORR:   gain_d = reg_wdata;
            `SCOC_ADDR_OC_CONFIG: begin
               en_d  = reg_wdata[`SCOC_CFG_EN_BIT];
               pol_d = reg_wdata[`SCOC_CFG_POL_BIT];
               rsv_d = reg_wdata[`SCOC_CFG_RSV_BIT];
               num_d = reg_wdata[`SCOC_CFG_NUM_MSB:`SCOC_CFG_NUM_LSB];
            end
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            `SCOC_ADDR_OFFSET_HIGH: rdata_d = offh_q;
            `SCOC_ADDR_OFFSET_LOW:  rdata_d = {offl_q, 8'h00};
            `SCOC_ADDR_GAIN_CORR:   rdata_d = gain_q;
            `SCOC_ADDR_OC_CONFIG:   rdata_d = {en_q, pol_q, rsv_q, num_q, 8'h00};
            default:                rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         offh_q  <= `SCOC_RST_OFFSET_HIGH;
         offl_q  <= `SCOC_RST_OFFSET_LOW;
         gain_q  <= `SCOC_RST_GAIN_CORR;
         en_q    <= 1'b0;
         pol_q   <= 1'b0;
         rsv_q   <= 1'b0;
         num_q   <= `SCOC_RST_DEGLITCH;
         rdata_q <= 16'h0000;
      end else begin
         offh_q  <= offh_d;
         offl_q  <= offl_d;
         gain_q  <= gain_d;
         en_q    <= en_d;
         pol_q   <= pol_d;
         rsv_q   <= rsv_d;
         num_q   <= num_d;
         rdata_q <= rdata_d;
      end
   end

   // Offset then gain correction, saturated to 24 bits
   always_comb begin
      offset = $signed({offh_q, offl_q});
      diff   = $signed({raw_data[23], raw_data}) - $signed({offset[23], offset});
      gfac   = `SCOC_GAIN_UNITY + $signed({{2{gain_q[15]}}, gain_q});
      prod   = (43'(diff) * 43'(gfac)) >>> `SCOC_GAIN_SHIFT;
      corr_d = corr_q;
      cvld_d = raw_valid;
      if (raw_valid) begin
         if (prod > 43'sh00000_7FFFFF)
            corr_d = 24'h7FFFFF;
         else if (prod < -43'sh00000_800000)
            corr_d = 24'h800000;
         else
            corr_d = prod[23:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         corr_q <= '0;
         cvld_q <= 1'b0;
      end else begin
         corr_q <= corr_d;
         cvld_q <= cvld_d;
      end
   end

   // Start and stop are deliberately not wired into the filter path
   assign run           = en_q & converter_enable;
   assign ffi.run       = run;
   assign ffi.mod_bit   = mod_bit;
   assign ffi.mod_valid = mod_valid;

   scoc_sinc3 u_sinc3 (
      .clk   (clk),
      .rst_b (rst_b),
      .ff    (ffi.filt)
   );

   // Comparator and deglitch
   always_comb begin
      need   = deglitch_len(num_q);
      scaled = ffr_q;
      if ((ffi.result >>> `SCOC_FF_SHIFT) > 20'sh07FFF)
         scaled = 16'h7FFF;
      else if ((ffi.result >>> `SCOC_FF_SHIFT) < -20'sh08000)
         scaled = 16'h8000;
      else
         scaled = ffi.result[18:3];
      ffr_d  = ffr_q;
      hcnt_d = hcnt_q;
      lcnt_d = lcnt_q;
      hev_d  = hev_q;
      lev_d  = lev_q;
      if (!run) begin
         hcnt_d = 8'h00;
         lcnt_d = 8'h00;
         hev_d  = 1'b0;
         lev_d  = 1'b0;
      end else if (ffi.result_valid) begin
         ffr_d  = scaled;
         hcnt_d = dg_next(scaled > overcurrent_b_upper_limit, hcnt_q, need);
         lcnt_d = dg_next(scaled < overcurrent_b_lower_limit, lcnt_q, need);
         hev_d  = (hcnt_d >= need) && (hcnt_d != 8'h00);
         lev_d  = (lcnt_d >= need) && (lcnt_d != 8'h00);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ffr_q  <= '0;
         hcnt_q <= 8'h00;
         lcnt_q <= 8'h00;
         hev_q  <= 1'b0;
         lev_q  <= 1'b0;
      end else begin
         ffr_q  <= ffr_d;
         hcnt_q <= hcnt_d;
         lcnt_q <= lcnt_d;
         hev_q  <= hev_d;
         lev_q  <= lev_d;
      end
   end

   // Pin drive; open drain only pulls low, so a high level releases the pin
   always_comb begin
      fault = hev_q | lev_q;
      level = pol_q ? fault : ~fault;
      if (!shared_pin_source_select)
         level = shared_pin_gpio_level;
      if (shared_pin_output_format == scoc_pkg::SCOC_FMT_OPEN_DRAIN) begin
         pout_d = 1'b0;
         poe_d  = ~level;
      end else begin
         pout_d = level;
         poe_d  = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pout_q <= 1'b0;
         poe_q  <= 1'b0;
      end else begin
         pout_q <= pout_d;
         poe_q  <= poe_d;
      end
   end

   assign reg_rdata                = rdata_q;
   assign corrected_data           = corr_q;
   assign corrected_valid          = cvld_q;
   assign shared_pin_out           = pout_q;
   assign shared_pin_oe            = poe_q;
   assign overcurrent_b_high_event = hev_q;
   assign overcurrent_b_low_event  = lev_q;
   assign fast_filter_result       = ffr_q;
endmodule // scoc_top
